//--- mfs_pkg.sv
// package for the mac frame statistics register slice
package mfs_pkg;
	// ---------------------------------------------------------------
	// register byte addresses
	// ---------------------------------------------------------------
	localparam logic [11:0] MFS_RESV_A_ADDR = 12'h10C;
	localparam logic [11:0] MFS_RESV_B_ADDR = 12'h110;
	localparam logic [11:0] MFS_RX_ALL_ADDR = 12'h200;
	localparam logic [11:0] MFS_RX_GOOD_ADDR = 12'h204;
	localparam logic [11:0] MFS_TX_ALL_ADDR = 12'h300;
	// ---------------------------------------------------------------
	// widths and reset values
	// ---------------------------------------------------------------
	localparam int MFS_ADDR_W = 12;
	localparam int MFS_DATA_W = 32;
	localparam logic [31:0] MFS_RESV_RESET = 32'h0000_0000;
	localparam logic [31:0] MFS_TALLY_RESET = 32'h0000_0000;
	localparam logic [31:0] MFS_TALLY_STEP = 32'h0000_0001;
	localparam logic [31:0] MFS_READ_ZERO = 32'h0000_0000;
endpackage

//--- mfs_stats.sv
// frame statistics tallies and reserved control words behind an apb slave
//
// Behaviour
// RULE1 - software fills the first reserved control word with all ones
// RULE2 - software fills the second reserved control word with all ones
// RULE3 - 32-bit tally at 0x200 counts every received frame
// RULE4 - 32-bit tally at 0x204 counts only received frames judged valid
// RULE5 - tallies clear only on device reset, never on reads
// RULE6 - a tally at maximum wraps to zero on the next increment
// RULE7 - software keeps measurement intervals shorter than one full tally wrap
// RULE8 - software records start values and allows for wrap in differences
// RULE9 - transmitted-frame tally register sits at 0x300
// RULE10 - transmit tally is 32 bits, counts every frame, resets and wraps likewise
// RULE11 - writes to tally locations do not change the counts
//
// The APB register port was left to the implementer.
module mfs_stats
	import mfs_pkg::*;
#(
	parameter int TALLY_W = MFS_DATA_W
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [MFS_ADDR_W-1:0] paddr,
	input wire logic [MFS_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [MFS_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_frame_done,
	input wire logic rx_frame_good,
	input wire logic tx_frame_done,
	output logic resv_ctrl_ready
);
	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	logic access;
	logic wr_en;
	logic hit_resv_a;
	logic hit_resv_b;
	logic hit_tally;
	logic mapped;
	assign access = psel & penable;
	assign wr_en = access & pwrite;
	assign hit_resv_a = (paddr == MFS_RESV_A_ADDR);
	assign hit_resv_b = (paddr == MFS_RESV_B_ADDR);
	assign hit_tally = (paddr == MFS_RX_ALL_ADDR) | (paddr == MFS_RX_GOOD_ADDR) |
		(paddr == MFS_TX_ALL_ADDR);
	assign mapped = hit_resv_a | hit_resv_b | hit_tally;
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;

	// ---------------------------------------------------------------
	// reserved control words
	// ---------------------------------------------------------------
	logic [31:0] resv_a_q;
	logic [31:0] resv_b_q;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_lane
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					resv_a_q[gi*8 +: 8] <= MFS_RESV_RESET[gi*8 +: 8];
					resv_b_q[gi*8 +: 8] <= MFS_RESV_RESET[gi*8 +: 8];
				end else if (wr_en && pstrb[gi]) begin
					if (hit_resv_a) begin
						resv_a_q[gi*8 +: 8] <= pwdata[gi*8 +: 8];
					end
					if (hit_resv_b) begin
						resv_b_q[gi*8 +: 8] <= pwdata[gi*8 +: 8];
					end
				end
			end
			a_lane_write_a: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
				(wr_en && hit_resv_a && pstrb[gi])
				|=> resv_a_q[gi*8 +: 8] == $past(pwdata[gi*8 +: 8]))
				else $error("reserved word a lane write lost");
			a_lane_write_b: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
				(wr_en && hit_resv_b && pstrb[gi])
				|=> resv_b_q[gi*8 +: 8] == $past(pwdata[gi*8 +: 8]))
				else $error("reserved word b lane write lost");
		end
	endgenerate
	// all-ones in both words enables software mode
	assign resv_ctrl_ready = (&resv_a_q) & (&resv_b_q); // RULE1 RULE2

	// ---------------------------------------------------------------
	// frame tallies
	// ---------------------------------------------------------------
	logic [TALLY_W-1:0] rx_all_q;
	logic [TALLY_W-1:0] rx_good_q;
	logic [TALLY_W-1:0] tx_all_q;
	// tallies ignore the bus entirely; only reset clears them
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_all_q <= MFS_TALLY_RESET[TALLY_W-1:0]; // RULE5
		end else if (rx_frame_done) begin
			rx_all_q <= rx_all_q + MFS_TALLY_STEP[TALLY_W-1:0]; // RULE3 RULE6 RULE11
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_good_q <= MFS_TALLY_RESET[TALLY_W-1:0]; // RULE5
		end else if (rx_frame_done && rx_frame_good) begin
			rx_good_q <= rx_good_q + MFS_TALLY_STEP[TALLY_W-1:0]; // RULE4 RULE6 RULE11
		end
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_all_q <= MFS_TALLY_RESET[TALLY_W-1:0]; // RULE5
		end else if (tx_frame_done) begin
			tx_all_q <= tx_all_q + MFS_TALLY_STEP[TALLY_W-1:0]; // RULE10 RULE6 RULE11
		end
	end

	// ---------------------------------------------------------------
	// read data
	// ---------------------------------------------------------------
	logic [31:0] rdata_d;
	always_comb begin
		case (paddr)
			MFS_RESV_A_ADDR: rdata_d = resv_a_q;
			MFS_RESV_B_ADDR: rdata_d = resv_b_q;
			MFS_RX_ALL_ADDR: rdata_d = MFS_DATA_W'(rx_all_q); // RULE3
			MFS_RX_GOOD_ADDR: rdata_d = MFS_DATA_W'(rx_good_q); // RULE4
			MFS_TX_ALL_ADDR: rdata_d = MFS_DATA_W'(tx_all_q); // RULE9
			default: rdata_d = MFS_READ_ZERO;
		endcase
	end

	// read word captured at the end of the setup cycle, stands in access
	logic [31:0] rdata_q;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= MFS_READ_ZERO;
		end else if (psel && !penable) begin
			rdata_q <= rdata_d;
		end
	end
	assign prdata = rdata_q;

	// ---------------------------------------------------------------
	// tally assertions
	// ---------------------------------------------------------------
	a_rx_all_step: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
		rx_frame_done
		|=> rx_all_q == $past(rx_all_q) + MFS_TALLY_STEP[TALLY_W-1:0])
		else $error("rx all tally did not step");
	a_rx_all_hold: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
		!rx_frame_done
		|=> $stable(rx_all_q))
		else $error("rx all tally moved without a frame");
	a_rx_good_step: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
		(rx_frame_done && rx_frame_good)
		|=> rx_good_q == $past(rx_good_q) + MFS_TALLY_STEP[TALLY_W-1:0])
		else $error("rx good tally did not step");
	a_rx_good_hold: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
		!(rx_frame_done && rx_frame_good)
		|=> $stable(rx_good_q))
		else $error("rx good tally moved without a valid frame");
	a_tx_all_step: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
		tx_frame_done
		|=> tx_all_q == $past(tx_all_q) + MFS_TALLY_STEP[TALLY_W-1:0])
		else $error("tx tally did not step");
	a_tx_all_hold: assert property (@(posedge clk) disable iff (!reset_n) // RULE10
		!tx_frame_done
		|=> $stable(tx_all_q))
		else $error("tx tally moved without a frame");
	a_tally_wrap: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
		(rx_frame_done && &rx_all_q)
		|=> rx_all_q == MFS_TALLY_RESET[TALLY_W-1:0])
		else $error("rx tally did not wrap");
	a_good_wrap: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
		(rx_frame_done && rx_frame_good && &rx_good_q)
		|=> rx_good_q == MFS_TALLY_RESET[TALLY_W-1:0])
		else $error("rx good tally did not wrap");
	a_tx_wrap: assert property (@(posedge clk) disable iff (!reset_n) // RULE6
		(tx_frame_done && &tx_all_q)
		|=> tx_all_q == MFS_TALLY_RESET[TALLY_W-1:0])
		else $error("tx tally did not wrap");
	a_write_no_effect: assert property (@(posedge clk) disable iff (!reset_n) // RULE11
		(wr_en && hit_tally && !tx_frame_done)
		|=> $stable(tx_all_q))
		else $error("write changed tx tally");
	a_read_no_clear: assert property (@(posedge clk) disable iff (!reset_n) // RULE5
		(access && !pwrite && paddr == MFS_RX_ALL_ADDR && !rx_frame_done)
		|=> rx_all_q == $past(rx_all_q))
		else $error("read cleared rx tally");

	// ---------------------------------------------------------------
	// bus assertions
	// ---------------------------------------------------------------
	a_tx_read_map: assert property (@(posedge clk) disable iff (!reset_n) // RULE9
		(access && !pwrite && paddr == MFS_TX_ALL_ADDR && $past(psel && !penable))
		|-> prdata == MFS_DATA_W'($past(tx_all_q)))
		else $error("tx tally read wrong");
	a_rx_all_read: assert property (@(posedge clk) disable iff (!reset_n) // RULE3
		(access && !pwrite && paddr == MFS_RX_ALL_ADDR && $past(psel && !penable))
		|-> prdata == MFS_DATA_W'($past(rx_all_q)))
		else $error("rx all tally read wrong");
	a_rx_good_read: assert property (@(posedge clk) disable iff (!reset_n) // RULE4
		(access && !pwrite && paddr == MFS_RX_GOOD_ADDR && $past(psel && !penable))
		|-> prdata == MFS_DATA_W'($past(rx_good_q)))
		else $error("rx good tally read wrong");
	a_resv_a_read: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
		(access && !pwrite && hit_resv_a && $past(psel && !penable))
		|-> prdata == $past(resv_a_q))
		else $error("reserved word a read wrong");
	a_tally_no_err: assert property (@(posedge clk) disable iff (!reset_n) // RULE11
		(access && (hit_tally || hit_resv_a || hit_resv_b))
		|-> !pslverr)
		else $error("mapped access answered with an error");
	a_resv_a_hold: assert property (@(posedge clk) disable iff (!reset_n) // RULE1
		!(wr_en && hit_resv_a)
		|=> $stable(resv_a_q))
		else $error("reserved word a changed without a write");
	a_resv_b_hold: assert property (@(posedge clk) disable iff (!reset_n) // RULE2
		!(wr_en && hit_resv_b)
		|=> $stable(resv_b_q))
		else $error("reserved word b changed without a write");
endmodule

//--- mfs_stats_tb_top.sv
// self-checking bench for the frame statistics register slice
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
module mfs_stats_tb_top
	import mfs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NARROW_W = 2;
	localparam logic [31:0] NARROW_MASK = ~(32'hFFFF_FFFF << NARROW_W);
	logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic rx_frame_done = 0, rx_frame_good = 0, tx_frame_done = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd, prdata_w, rd2, start_v;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, resv_ctrl_ready;
	int failures = 0, samples_checked = 0;
	logic [11:0] adr [5] = '{MFS_RESV_A_ADDR, MFS_RESV_B_ADDR, MFS_RX_ALL_ADDR,
		MFS_RX_GOOD_ADDR, MFS_TX_ALL_ADDR};
	logic [31:0] exp_v [5] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h6, 32'h4, 32'h4};
	always #2.5 clk = ~clk;
	mfs_stats DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_frame_done(rx_frame_done),
		.rx_frame_good(rx_frame_good), .tx_frame_done(tx_frame_done),
		.resv_ctrl_ready(resv_ctrl_ready));
	mfs_stats #(.TALLY_W(NARROW_W)) DUT_NARROW (.clk(clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata_w), .pready(), .pslverr(), .rx_frame_done(rx_frame_done),
		.rx_frame_good(rx_frame_good), .tx_frame_done(tx_frame_done), .resv_ctrl_ready());
	// ---------------------------------------------------------------
	// apb master, frame pulses and closing
	// ---------------------------------------------------------------
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		rd2 = prdata_w;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic chk_rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, 4'h0);
		`CHK("prdata", e, rd)
		`CHK("pslverr", 1'b0, er)
		`CHK("narrow prdata", ((a < MFS_RX_ALL_ADDR) ? e : (e & NARROW_MASK)), rd2)
	endtask
	task automatic frame(input logic r, input logic g, input logic t);
		@(posedge clk);
		{rx_frame_done, rx_frame_good, tx_frame_done} <= {r, g, t};
		@(posedge clk);
		{rx_frame_done, rx_frame_good, tx_frame_done} <= 3'b000;
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#10us;
		failures++;
		end_of_test();
	end
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 5; i++) chk_rd(adr[i], 32'h0000_0000);
		apb(1'b1, MFS_RESV_A_ADDR, 32'hFFFF_FFFF, 4'h1);
		chk_rd(MFS_RESV_A_ADDR, 32'h0000_00FF);
		apb(1'b1, MFS_RESV_A_ADDR, 32'hFFFF_FFFF, 4'hE);
		`CHK("resv_ctrl_ready", 1'b0, resv_ctrl_ready)
		apb(1'b1, MFS_RESV_B_ADDR, 32'hFFFF_FFFF, 4'hF);
		chk_rd(MFS_RESV_B_ADDR, 32'hFFFF_FFFF);
		`CHK("resv_ctrl_ready", 1'b1, resv_ctrl_ready)
		repeat (3) frame(1'b1, 1'b1, 1'b0);
		repeat (2) frame(1'b1, 1'b0, 1'b1);
		frame(1'b0, 1'b1, 1'b1);
		frame(1'b1, 1'b1, 1'b1);
		for (int i = 0; i < 5; i++) chk_rd(adr[i], exp_v[i]);
		for (int i = 2; i < 5; i++) apb(1'b1, adr[i], 32'hFFFF_FFFF, 4'hF);
		for (int i = 2; i < 5; i++) chk_rd(adr[i], exp_v[i]);
		chk_rd(MFS_RX_ALL_ADDR, 32'h0000_0006);
		start_v = rd2;
		repeat (2) frame(1'b1, 1'b0, 1'b0);
		chk_rd(MFS_RX_ALL_ADDR, 32'h0000_0008);
		`CHK("wrap difference", 32'h0000_0002, ((rd2 - start_v) & NARROW_MASK))
		apb(1'b0, 12'h208, 32'h0000_0000, 4'h0);
		`CHK("pslverr", 1'b1, er)
		`CHK("unmapped prdata", 32'h0000_0000, rd)
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 5; i++) chk_rd(adr[i], 32'h0000_0000);
		`CHK("resv_ctrl_ready", 1'b0, resv_ctrl_ready)
		end_of_test();
	end
endmodule
